/* File: inc/sapp_pkg.sv */
// Purpose: shared constants and types for the converter control port
// Assumes: 100 MHz core clock, 12-bit two's complement results
// Notes: all times are kept in ns; cycle counts derive from them
`default_nettype none
package sapp_pkg;
    localparam int RES_W = 12;
    localparam int CLK_NS = 10;
    localparam int CONV_TYP_NS = 650;
    localparam int CONV_MAX_NS = 750;
    localparam int ACQ_NS = 100;
    localparam int THRU_NS = 800;
    localparam int NAP_WAKE_NS = 200;
    localparam int SLEEP_WAKE_NS = 10000000;
    // Least times round up, longest times round down
    localparam int CONV_TYP_CYC = CONV_TYP_NS / CLK_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
    localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int THRU_CYC = THRU_NS / CLK_NS;
    localparam int NAP_WAKE_CYC = NAP_WAKE_NS / CLK_NS;
    localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_NS / CLK_NS;
    localparam int BIT_CYC = CONV_TYP_CYC / RES_W;
    localparam int CNT_W = 20;
    localparam int IDX_W = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [RES_W-1:0] MID_CODE = 12'h800;
    localparam logic [RES_W-1:0] ZERO_CODE = 12'h000;
    localparam logic [IDX_W-1:0] MSB_IDX = 4'hb;
    localparam logic [IDX_W-1:0] LSB_IDX = 4'h0;
    localparam int SIGN_BIT = RES_W - 1;

    typedef enum logic [6:0] {
        ST_DOWN = 7'h01,
        ST_WAKE = 7'h02,
        ST_IDLE = 7'h04,
        ST_CONV = 7'h08,
        ST_PUSH = 7'h10,
        ST_LOAD = 7'h20,
        ST_ACQ = 7'h40
    } sapp_state_e;

    typedef struct packed {
        logic csN;
        logic rdN;
        logic startN;
        logic pdN;
        logic lightSel;
    } sapp_pins_s;

    typedef struct packed {
        logic logicOn;
        logic refOn;
        logic biasOn;
    } sapp_power_s;
endpackage
`default_nettype wire

/* File: hdl/sapp_fifo.sv */
// Purpose: result queue between the successive-approximation core and the output latch
// Assumes: depth is a power of two
// Notes: read data comes straight from the storage flops
`timescale 1ns/1ps
`default_nettype none
module sapp_fifo #(
    parameter int W = sapp_pkg::RES_W,
    parameter int D = sapp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wrPtr_r;
    logic [AW:0] rdPtr_r;
    logic full;
    logic empty;
    logic doWr;
    logic doRd;

    assign empty = wrPtr_r == rdPtr_r;
    assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    assign inReady = ~full;
    assign outValid = ~empty;
    assign outData = mem[rdPtr_r[AW-1:0]];
    assign doWr = ce & inValid & ~full;
    assign doRd = ce & outReady & ~empty;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sapp_core.sv */
// Purpose: conversion control and parallel result port of a sampling converter
// Assumes: comparator decision is valid on clk; host pins are asynchronous
// Notes: busyN, dataOe and power flags decode registered state
//
// Overview of operation
// RL1: Results are two's complement, 4096 steps span.
// RL2: Conversion takes typically 650 ns, at most 750; the core converts in 600 ns (12 bits of 5 cycles).
// RL3: At least 100 ns acquisition precedes next start.
// RL4: Back-to-back throughput period is 800 ns.
// RL5: Light power-down wake within 200 ns.
// RL6: Light power-down keeps logic and reference powered.
// RL7: Host waits 10 ms after deep power-down.
// RL8: Shutdown input low means power-down state.
// RL9: Select high picks light, low picks deep.
// RL10: Start falling edge with chip select low converts.
// RL11: Starts during a conversion are ignored.
// RL12: Busy low for whole conversion, high after.
// RL13: Chip select and read low drive data continuously.
// RL14: Data driven only while read strobe is low.
// RL15: Combined start/read shows old, then new result.
// RL16: Slow-memory host holds line low until busy rises.
// RL17: ROM style pulse starts conversion, returns previous.
// RL18: Zero input gives all zeros; one below, ones.
// RL19: Host keeps bus quiet while converting.
// RL20: Result moves to holding latch at conversion end.
// RL21: Host lowers chip select before lowering start.
`timescale 1ns/1ps
`default_nettype none
module sapp_core #(
    parameter int FIFO_D = sapp_pkg::FIFO_DEPTH,
    parameter int SLEEP_WAKE = sapp_pkg::SLEEP_WAKE_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Host pins
    input wire logic csN,
    input wire logic rdN,
    input wire logic startConvN,
    input wire logic powerDownN,
    input wire logic lightDeepSelect,
    output logic busyN,
    output logic [sapp_pkg::RES_W-1:0] dataOut,
    output logic dataOe,
    // Analog core
    input wire logic compIn,
    output logic [sapp_pkg::RES_W-1:0] dacCode,
    output logic sampleTrack,
    output var sapp_pkg::sapp_power_s power,
    // Result queue control
    input wire logic resultHold
);
    localparam logic [sapp_pkg::CNT_W-1:0] BitLast = sapp_pkg::CNT_W'(sapp_pkg::BIT_CYC - 1);
    localparam logic [sapp_pkg::CNT_W-1:0] AcqLast = sapp_pkg::CNT_W'(sapp_pkg::ACQ_CYC - 1);
    // Sync and entry cycles count against the light wake budget
    localparam int WakeLag = 3;
    localparam logic [sapp_pkg::CNT_W-1:0] NapLast =
        sapp_pkg::CNT_W'(sapp_pkg::NAP_WAKE_CYC - 1 - WakeLag);
    localparam logic [sapp_pkg::CNT_W-1:0] SleepLast = sapp_pkg::CNT_W'(SLEEP_WAKE - 1);
    localparam int ConvMax = sapp_pkg::CONV_MAX_CYC;
    localparam int NapMax = sapp_pkg::NAP_WAKE_CYC;

    // Two-stage synchronisers; stage one feeds only stage two
    sapp_pkg::sapp_pins_s pinsS1_r;
    sapp_pkg::sapp_pins_s pinsS2_r;
    logic startS3_r;
    sapp_pkg::sapp_state_e state_r;
    sapp_pkg::sapp_state_e stateNxt;
    logic [sapp_pkg::CNT_W-1:0] cnt_r;
    logic [sapp_pkg::CNT_W-1:0] cntNxt;
    logic [sapp_pkg::IDX_W-1:0] bitIdx_r;
    logic [sapp_pkg::RES_W-1:0] trial_r;
    logic [sapp_pkg::RES_W-1:0] trialNxt;
    logic [sapp_pkg::RES_W-1:0] hold_r;
    logic [sapp_pkg::RES_W-1:0] resultCode;
    logic [sapp_pkg::RES_W-1:0] fifoOutData;
    logic deep_r;
    logic startFall;
    logic startAcc;
    logic bitEnd;
    logic lastBit;
    logic pdReq;
    logic fifoInReady;
    logic fifoOutValid;
    logic pushValid;
    logic latchLoad;
    logic stDown;
    logic stConv;
    logic stIdle;
    logic stAcq;
    logic stWake;
    logic [sapp_pkg::CNT_W-1:0] wakeLast;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinsS1_r <= '1;
            pinsS2_r <= '1;
            startS3_r <= 1'b1;
        end else if (ce) begin
            pinsS1_r <= '{csN, rdN, startConvN, powerDownN, lightDeepSelect};
            pinsS2_r <= pinsS1_r;
            startS3_r <= pinsS2_r.startN;
        end
    end

    // Decode
    assign stDown = state_r == sapp_pkg::ST_DOWN;
    assign stWake = state_r == sapp_pkg::ST_WAKE;
    assign stIdle = state_r == sapp_pkg::ST_IDLE;
    assign stConv = state_r == sapp_pkg::ST_CONV;
    assign stAcq = state_r == sapp_pkg::ST_ACQ;
    assign startFall = startS3_r & ~pinsS2_r.startN; // RL10
    // Select must already be low at the edge, else the start is lost
    assign startAcc = startFall & ~pinsS2_r.csN; // RL21
    assign pdReq = ~pinsS2_r.pdN; // RL8
    assign bitEnd = cnt_r == BitLast;
    assign lastBit = bitIdx_r == sapp_pkg::LSB_IDX;
    assign wakeLast = deep_r ? SleepLast : NapLast; // RL5
    assign pushValid = state_r == sapp_pkg::ST_PUSH;
    assign latchLoad = ce & fifoOutValid & ~resultHold; // RL20
    // Offset-binary search, sign bit flipped on the way out
    assign resultCode = {~trial_r[sapp_pkg::SIGN_BIT], trial_r[sapp_pkg::SIGN_BIT-1:0]}; // RL1 RL18

    // Per-bit trial update: decide current bit, arm the next lower one
    for (genvar i = 0; i < sapp_pkg::RES_W; i++) begin : gTrial
        assign trialNxt[i] = (bitIdx_r == sapp_pkg::IDX_W'(i)) ? compIn :
            (bitIdx_r == sapp_pkg::IDX_W'(i + 1)) ? 1'b1 : trial_r[i];
    end

    always_comb begin
        stateNxt = state_r;
        cntNxt = '0;
        if (pdReq) begin
            stateNxt = sapp_pkg::ST_DOWN; // RL8
        end else begin
            case (state_r)
                sapp_pkg::ST_DOWN: begin
                    stateNxt = sapp_pkg::ST_WAKE;
                end
                sapp_pkg::ST_WAKE: begin
                    cntNxt = cnt_r + 1'b1;
                    if (cnt_r >= wakeLast) begin
                        stateNxt = sapp_pkg::ST_IDLE; // RL5
                    end
                end
                sapp_pkg::ST_IDLE: begin
                    // Full queue refuses the start rather than drop a result
                    if (startAcc && fifoInReady) begin
                        stateNxt = sapp_pkg::ST_CONV; // RL10 RL17
                    end
                end
                sapp_pkg::ST_CONV: begin
                    cntNxt = cnt_r + 1'b1;
                    if (bitEnd) begin
                        cntNxt = '0;
                        if (lastBit) begin
                            stateNxt = sapp_pkg::ST_PUSH; // RL2
                        end
                    end
                end
                sapp_pkg::ST_PUSH: begin
                    if (fifoInReady) begin
                        stateNxt = sapp_pkg::ST_LOAD;
                    end
                end
                sapp_pkg::ST_LOAD: begin
                    // Held queue releases busy without waiting for the latch
                    if (latchLoad || resultHold) begin
                        stateNxt = sapp_pkg::ST_ACQ; // RL15
                    end
                end
                sapp_pkg::ST_ACQ: begin
                    cntNxt = cnt_r + 1'b1;
                    if (cnt_r == AcqLast) begin
                        stateNxt = sapp_pkg::ST_IDLE; // RL3 RL4
                    end
                end
                default: begin
                    stateNxt = sapp_pkg::ST_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= sapp_pkg::ST_DOWN;
            cnt_r <= '0;
        end else if (ce) begin
            state_r <= stateNxt;
            cnt_r <= cntNxt;
        end
    end

    // Search register; starts while converting never reload it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            trial_r <= sapp_pkg::MID_CODE;
            bitIdx_r <= sapp_pkg::MSB_IDX;
        end else if (ce) begin
            if (stIdle && startAcc && fifoInReady && !pdReq) begin
                trial_r <= sapp_pkg::MID_CODE;
                bitIdx_r <= sapp_pkg::MSB_IDX;
            end else if (stConv && bitEnd && !pdReq) begin // RL11
                trial_r <= trialNxt;
                bitIdx_r <= lastBit ? bitIdx_r : bitIdx_r - 1'b1;
            end
        end
    end

    // Holding latch and sleep depth memory
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_r <= sapp_pkg::ZERO_CODE;
            deep_r <= 1'b0;
        end else if (ce) begin
            if (latchLoad) begin
                hold_r <= fifoOutData; // RL20 RL15
            end
            if (stDown) begin
                deep_r <= ~pinsS2_r.lightSel; // RL9
            end
        end
    end

    sapp_fifo #(
        .W(sapp_pkg::RES_W),
        .D(FIFO_D)
    ) uQueue (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(resultCode),
        .outValid(fifoOutValid),
        .outReady(~resultHold),
        .outData(fifoOutData)
    );

    // Pin outputs
    assign busyN = ~(stConv | pushValid | (state_r == sapp_pkg::ST_LOAD)); // RL12
    assign dataOe = ~pinsS2_r.csN & ~pinsS2_r.rdN; // RL13 RL14
    assign dataOut = hold_r;
    assign dacCode = trial_r;
    assign sampleTrack = stIdle | stAcq;
    // Light power-down keeps logic and reference alive, bias off
    assign power.biasOn = ~stDown;
    assign power.refOn = ~stDown | pinsS2_r.lightSel; // RL6 RL9
    assign power.logicOn = ~stDown | pinsS2_r.lightSel; // RL6

    // Assertion helpers
    logic [sapp_pkg::CNT_W-1:0] convCnt_r;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            convCnt_r <= '0;
        end else if (ce) begin
            convCnt_r <= stConv ? convCnt_r + 1'b1 : '0;
        end
    end

    sequence s_accept;
        ce && stIdle && startAcc && fifoInReady && !pdReq;
    endsequence

    sequence s_busyLow;
        !busyN && stConv;
    endsequence

    property p_convLen;
        @(posedge clk) disable iff (!rstn)
        stConv |-> convCnt_r < ConvMax;
    endproperty
    a_convLen: assert property (p_convLen) else $error("conversion too long"); // RL2

    property p_start;
        @(posedge clk) disable iff (!rstn)
        s_accept |=> s_busyLow ##0 (trial_r == sapp_pkg::MID_CODE);
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // RL10 RL12

    property p_ignore;
        @(posedge clk) disable iff (!rstn)
        (ce && stConv && startAcc && !bitEnd && !pdReq) |=> bitIdx_r == $past(bitIdx_r);
    endproperty
    a_ignore: assert property (p_ignore) else $error("restart during conversion"); // RL11

    property p_oe;
        @(posedge clk) disable iff (!rstn)
        (pinsS2_r.rdN || pinsS2_r.csN) |-> !dataOe;
    endproperty
    a_oe: assert property (p_oe) else $error("data driven without read"); // RL14

    property p_busyRise;
        @(posedge clk) disable iff (!rstn)
        ($rose(busyN) && stAcq && !$past(resultHold)) |->
            $past(latchLoad) && dataOut == $past(fifoOutData);
    endproperty
    a_busyRise: assert property (p_busyRise) else $error("busy rose before latch"); // RL15

    property p_down;
        @(posedge clk) disable iff (!rstn)
        (ce && pdReq) |=> stDown && busyN;
    endproperty
    a_down: assert property (p_down) else $error("shutdown not entered"); // RL8

    property p_nap;
        @(posedge clk) disable iff (!rstn)
        stDown |-> (power.refOn == pinsS2_r.lightSel) && !power.biasOn;
    endproperty
    a_nap: assert property (p_nap) else $error("power flags wrong in shutdown"); // RL6 RL9

    property p_napWake;
        @(posedge clk) disable iff (!rstn)
        (stWake && !deep_r) |-> cnt_r < NapMax;
    endproperty
    a_napWake: assert property (p_napWake) else $error("light wake too slow"); // RL5

    property p_acq;
        @(posedge clk) disable iff (!rstn)
        ($rose(stAcq) && !pdReq) |-> (stAcq || stDown)[*8];
    endproperty
    a_acq: assert property (p_acq) else $error("acquisition cut short"); // RL3

    property p_code;
        @(posedge clk) disable iff (!rstn)
        pushValid |-> resultCode[sapp_pkg::SIGN_BIT] != trial_r[sapp_pkg::SIGN_BIT]
            && resultCode[sapp_pkg::SIGN_BIT-1:0] == trial_r[sapp_pkg::SIGN_BIT-1:0];
    endproperty
    a_code: assert property (p_code) else $error("result coding wrong"); // RL1 RL18
endmodule
`default_nettype wire

/* File: sim/sapp_host.sv */
// Purpose: host bus model driving the converter port pins
// Assumes: pins move only on the falling clock edge
// Notes: data read while the port is not driving comes back inverted
`timescale 1ns/1ps
`default_nettype none
module sapp_host (
    // Clock and status
    input wire logic clk,
    input wire logic busyN,
    input wire logic dataOe,
    input wire logic [11:0] dataOut,
    // Bus pins
    output logic csN,
    output logic rdN,
    output logic startConvN,
    // Captured read data
    output logic [11:0] seen
);
    initial begin
        csN = 1'h1;
        rdN = 1'h1;
        startConvN = 1'h1;
        seen = 12'h000;
    end
    task automatic bus(input logic c, input logic r);
        @(negedge clk);
        csN = c;
        rdN = r;
    endtask
    // Slow style holds the line low as a wait state
    task automatic start(input logic tied, input logic slow);
        int n;
        @(negedge clk);
        startConvN = 1'h0;
        if (tied) rdN = 1'h0;
        n = 0;
        if (slow) begin
            while (busyN === 1'h1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            while (busyN !== 1'h1 && n < 200) begin
                @(negedge clk);
                n++;
            end
        end else begin
            repeat (4) @(negedge clk);
        end
        seen = (dataOe === 1'h1) ? dataOut : ~dataOut;
        startConvN = 1'h1;
        if (tied) rdN = 1'h1;
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the converter control port
// Assumes: SLEEP_WAKE shortened to 50 cycles
// Notes: comparator modelled from a target code held in ain
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic pdN = 1'h1;
    logic sel = 1'h1;
    logic hold = 1'h0;
    logic [11:0] ain = 12'h000;
    logic csN, rdN, stN, busyN, oe, comp, trk;
    logic [11:0] dOut, dac, seen;
    sapp_pkg::sapp_power_s pwr;
    logic [11:0] codes [5] = '{12'h000, 12'hfff, 12'h7ff, 12'h800, 12'h5a3};
    int nFail = 0;
    int totalChecks = 0;
    int lowCnt = 0;
    int lowLen = 0;
    int nConv = 0;
    int cyc = 0;
    int fallAt = 0;
    int period = 0;
    int k;
    always #5 clk = ~clk;
    // Offset-binary comparator against the trial code
    assign comp = ((ain ^ 12'h800) >= dac);
    sapp_host host (.clk(clk), .busyN(busyN), .dataOe(oe), .dataOut(dOut),
        .csN(csN), .rdN(rdN), .startConvN(stN), .seen(seen));
    sapp_core #(.SLEEP_WAKE(50)) dut (.clk(clk), .rstn(rstn), .ce(1'h1),
        .csN(csN), .rdN(rdN), .startConvN(stN), .powerDownN(pdN),
        .lightDeepSelect(sel), .busyN(busyN), .dataOut(dOut), .dataOe(oe),
        .compIn(comp), .dacCode(dac), .sampleTrack(trk), .power(pwr),
        .resultHold(hold));
    always @(posedge clk) begin
        if (busyN === 1'h0) begin
            if (lowCnt == 0) begin
                period = cyc - fallAt;
                fallAt = cyc;
            end
            lowCnt++;
        end else if (lowCnt != 0) begin
            lowLen = lowCnt;
            lowCnt = 0;
            nConv++;
        end
        cyc++;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        totalChecks++;
        if (s !== e) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Host leaves the acquisition gap before any further start
    task automatic settle();
        int n;
        n = 0;
        while (busyN !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (sapp_pkg::ACQ_CYC) @(negedge clk);
    endtask
    task automatic conv(input logic [11:0] v, input logic tied, input logic slow);
        ain = v;
        host.start(tied, slow);
        settle();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        $display("ERROR watchdog expired");
        completeRun();
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'h1;
        chk("busyN", busyN, 1'h1);
        chk("dataOut", dOut, 12'h000);
        repeat (30) @(negedge clk);
        host.bus(1'h0, 1'h1);
        repeat (3) @(negedge clk);
        chk("dataOe", oe, 1'h0);
        for (int i = 0; i < 5; i++) begin
            conv(codes[i], 1'h0, 1'h0);
            chk("dataOut", dOut, codes[i]);
            chk("busyLow", lowLen <= sapp_pkg::CONV_MAX_CYC && lowLen >= 60, 1'h1);
            if (i > 0) chk("period", period <= sapp_pkg::THRU_CYC, 1'h1);
        end
        host.bus(1'h0, 1'h0);
        repeat (3) @(negedge clk);
        chk("dataOe", oe, 1'h1);
        ain = 12'h321;
        host.start(1'h0, 1'h0);
        chk("busyN", busyN, 1'h0);
        chk("dataOe", oe, 1'h1);
        chk("sampleTrack", trk, 1'h0);
        settle();
        chk("dataOut", dOut, 12'h321);
        chk("sampleTrack", trk, 1'h1);
        host.bus(1'h0, 1'h1);
        k = nConv;
        ain = 12'h0f0;
        host.start(1'h0, 1'h0);
        repeat (10) @(negedge clk);
        host.start(1'h0, 1'h0);
        settle();
        repeat (20) @(negedge clk);
        chk("nConv", nConv, k + 1);
        chk("dataOut", dOut, 12'h0f0);
        host.bus(1'h1, 1'h1);
        k = nConv;
        host.start(1'h0, 1'h0);
        repeat (20) @(negedge clk);
        chk("nConv", nConv, k);
        host.bus(1'h0, 1'h1);
        conv(12'h3c5, 1'h1, 1'h0);
        chk("romSeen", seen, 12'h0f0);
        chk("dataOut", dOut, 12'h3c5);
        conv(12'h0a6, 1'h1, 1'h1);
        chk("slowSeen", seen, 12'h0a6);
        pdN = 1'h0;
        repeat (5) @(negedge clk);
        chk("power", pwr, 3'h6);
        chk("busyN", busyN, 1'h1);
        pdN = 1'h1;
        repeat (sapp_pkg::NAP_WAKE_CYC) @(negedge clk);
        chk("napReady", trk, 1'h1);
        conv(12'h111, 1'h0, 1'h0);
        chk("dataOut", dOut, 12'h111);
        sel = 1'h0;
        pdN = 1'h0;
        repeat (5) @(negedge clk);
        chk("refBias", {pwr.refOn, pwr.biasOn}, 2'h0);
        pdN = 1'h1;
        repeat (60) @(negedge clk);
        conv(12'h222, 1'h0, 1'h0);
        chk("dataOut", dOut, 12'h222);
        host.start(1'h0, 1'h0);
        repeat (10) @(negedge clk);
        pdN = 1'h0;
        repeat (4) @(negedge clk);
        chk("busyN", busyN, 1'h1);
        pdN = 1'h1;
        repeat (60) @(negedge clk);
        // Stalled drain lets the queue fill until starts are refused
        hold = 1'h1;
        for (int i = 0; i < 16; i++) conv(12'h0a0 + 12'(i), 1'h0, 1'h0);
        k = nConv;
        host.start(1'h0, 1'h0);
        repeat (20) @(negedge clk);
        chk("fullRefuse", nConv, k);
        hold = 1'h0;
        repeat (40) @(negedge clk);
        chk("dataOut", dOut, 12'h0af);
        completeRun();
    end
endmodule
`default_nettype wire
